// ---- core/clbc_pkg.sv ----
// Package: constants and types for the local bus cycle interface
// How it works
// - Memory space covers all 32-bit addresses; I/O addresses stay below 0001_0000.
// - Coprocessor transfers are I/O cycles at 800000F8 through 800000FF.
// - Active-low lane select n covers data bits 8n to 8n+7.
// - Number of asserted lane selects equals operand size, one to four bytes.
// - Writes using only the upper half copy those bytes onto the lower half.
// - Lane 2 copies to 0, lane 3 to 1, both to 0 and 1 only.
// - Memory/IO, data/code and write/read are valid while the strobe is asserted.
// - Lock output valid at first locked cycle, negated when its last one terminates; a first locked cycle entered by pipelining never raises it.
// - Type codes 000 ack, 010/011 I/O, 100 code, 101 halt, 110/111 memory data.
// - Type 001 is never driven while the address strobe is asserted.
// - Halt drives address 2 with lane 2; shutdown address 0 with lane 0.
// - Address strobe asserted in first and pipelined second bus states.
// - Termination latches read data on reads and acknowledges; writes just end.
// - Termination ignored in the first bus state, then sampled each state.
// - Next-address request drives the following cycle early only when one is pending.
// - Half-width input restricts cycle to lower lanes; no effect for lanes 0/1 only.
// - Half-width with lane 2 or 3 moves upper bytes over lower data lines.
// - Operand spanning both halves with half-width runs an extra 16-bit cycle.
// - Address given as four lane selects plus thirty word address bits.
// - Writes, halt and shutdown drive all 32 data lines.
// - A bus cycle lasts at least two internal clocks, longer until terminated.
// - Signals named with _n are active low; others active high.
package clbc_pkg;
	localparam logic [31:0] IO_ADDR_MAX = 32'h0000_FFFF;
	localparam logic [31:0] COP_ADDR_LO = 32'h8000_00F8;
	localparam logic [31:0] COP_ADDR_HI = 32'h8000_00FF;
	localparam logic [29:0] HALT_WADDR = 30'h0000_0000;
	localparam logic [3:0] HALT_LANES = 4'h4;
	localparam logic [3:0] SHUT_LANES = 4'h1;
	localparam logic [3:0] LOW_LANES = 4'h3;
	localparam logic [3:0] HIGH_LANES = 4'hC;
	localparam logic [3:0] RST_LANES_N = 4'h0;
	localparam logic [29:0] RST_WADDR = 30'h3FFF_FFFF;
	localparam logic [2:0] RST_TYPE = 3'h2;
	localparam logic [2:0] IDLE_TYPE = 3'h1;
	localparam int MIN_STATES = 2;
	// Cycle type code {mem_io, data_code, write_read}
	typedef enum logic [2:0] {
		CLBC_INTA = 3'h0,
		CLBC_IO_RD = 3'h2,
		CLBC_IO_WR = 3'h3,
		CLBC_CODE_RD = 3'h4,
		CLBC_HALT_SHUT = 3'h5,
		CLBC_MEM_RD = 3'h6,
		CLBC_MEM_WR = 3'h7
	} clbc_type_t;
	typedef enum logic [3:0] {
		CLBC_IDLE = 4'h1,
		CLBC_FIRST = 4'h2,
		CLBC_LATER = 4'h4,
		CLBC_PIPE = 4'h8
	} clbc_state_t;
endpackage

// ---- core/clbc_req_if.sv ----
// Interface: one internal bus request between the core and the lane helper
interface clbc_req_if;
	import clbc_pkg::*;
	logic [29:0] waddr;
	logic [3:0] lanes;
	logic [31:0] wdata;
	logic [2:0] ctype;
	logic [31:0] drv_data;
	logic upper_only;
	logic spans;
	modport core (output waddr, output lanes, output wdata, output ctype,
		input drv_data, input upper_only, input spans);
	modport lane (input waddr, input lanes, input wdata, input ctype,
		output drv_data, output upper_only, output spans);
endinterface

// ---- core/clbc_lane_map.sv ----
// Lane helper: write duplication and half-width classification
module clbc_lane_map import clbc_pkg::*; (
	clbc_req_if.lane r
);
	wire lo_any = |r.lanes[1:0];
	wire hi_any = |r.lanes[3:2];
	assign r.upper_only = hi_any && !lo_any;
	assign r.spans = hi_any && lo_any;
	// Copy upper bytes down so a 16-bit slave sees them without a second cycle
	assign r.drv_data[31:16] = r.wdata[31:16];
	assign r.drv_data[15:0] = r.upper_only ? r.wdata[31:16] : r.wdata[15:0];
endmodule

// ---- core/clbc_bus_cycle.sv ----
// Top: processor-side local bus cycle sequencer
module clbc_bus_cycle import clbc_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic clk_en,
	// Internal request side
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [29:0] req_waddr,
	input wire logic [3:0] req_lanes,
	input wire logic [2:0] req_type,
	input wire logic req_lock,
	input wire logic req_halt,
	input wire logic [31:0] req_wdata,
	output logic rsp_valid,
	output logic [31:0] rsp_rdata,
	// Pins
	output logic [29:0] word_address_bits,
	output logic [3:0] byte_lane_select_n,
	output logic mem_io,
	output logic data_code,
	output logic write_read,
	output logic lock_n,
	output logic address_strobe_n,
	input wire logic ready_n,
	input wire logic next_address_request_n,
	input wire logic half_width_bus_n,
	input wire logic [31:0] data_lines_in,
	output logic [31:0] data_lines_out,
	output logic data_lines_oe_n
);
	// ------------------------------------------------------------
	// Pin input synchronisers
	// ------------------------------------------------------------
	logic [2:0] rdy_s_reg, na_s_reg, bs_s_reg;
	logic rdy_reg, na_reg, bs_reg;
	always_ff @(posedge clock) begin
		if (srst) begin
			rdy_s_reg <= 3'h7;
			na_s_reg <= 3'h7;
			bs_s_reg <= 3'h7;
			rdy_reg <= 1'b1;
			na_reg <= 1'b1;
			bs_reg <= 1'b1;
		end else if (clk_en) begin
			rdy_s_reg <= {rdy_s_reg[1:0], ready_n};
			na_s_reg <= {na_s_reg[1:0], next_address_request_n};
			bs_s_reg <= {bs_s_reg[1:0], half_width_bus_n};
			if (rdy_s_reg[1] == rdy_s_reg[2]) rdy_reg <= rdy_s_reg[2];
			if (na_s_reg[1] == na_s_reg[2]) na_reg <= na_s_reg[2];
			if (bs_s_reg[1] == bs_s_reg[2]) bs_reg <= bs_s_reg[2];
		end
	end
	wire ready_seen = !rdy_reg;
	wire na_seen = !na_reg;
	wire half_seen = !bs_reg;

	// ------------------------------------------------------------
	// Current cycle registers
	// ------------------------------------------------------------
	clbc_state_t state_reg, state_next;
	logic [29:0] waddr_reg;
	logic [3:0] lanes_reg;
	logic [2:0] type_reg;
	logic [31:0] wdata_reg;
	logic lock_reg;
	logic second_reg;
	logic [31:0] rdata_reg;
	logic rsp_reg;
	logic lock_out_reg;
	logic [29:0] p_waddr_reg;
	logic [3:0] p_lanes_reg;
	logic [2:0] p_type_reg;
	logic [31:0] p_wdata_reg;
	logic p_lock_reg;
	logic p_full_reg;
	logic pipe_fresh_reg;
	logic pipe_start_reg;

	clbc_req_if cur ();
	assign cur.waddr = waddr_reg;
	assign cur.lanes = lanes_reg;
	assign cur.wdata = wdata_reg;
	assign cur.ctype = type_reg;
	clbc_lane_map u_map (.r(cur));

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire is_write = type_reg[0] && type_reg != CLBC_HALT_SHUT;
	wire is_read = !type_reg[0];
	wire drives_data = type_reg[0];
	// A promoted pipelined cycle enters LATER, but that is still its own first state
	wire can_end = (state_reg == CLBC_LATER && !pipe_start_reg)
		|| state_reg == CLBC_PIPE;
	wire term = can_end && ready_seen;
	// Extra 16-bit cycle only for an operand straddling both halves
	wire need_second = term && half_seen && cur.spans && !second_reg;
	wire cyc_done = term && !need_second;
	wire [3:0] second_lanes = lanes_reg & HIGH_LANES;
	// Halt and shutdown force the address, and force lane 2 or lane 0 depending on request lane 2
	wire [29:0] in_waddr = req_halt ? HALT_WADDR : req_waddr;
	wire [3:0] halt_lanes = req_lanes[2] ? HALT_LANES : SHUT_LANES;
	wire [3:0] in_lanes = req_halt ? halt_lanes : req_lanes;
	wire [2:0] in_type = req_halt ? 3'(CLBC_HALT_SHUT) : req_type;
	// Pipelined address only when the request is already waiting
	wire take_pipe = state_reg == CLBC_LATER && na_seen && req_valid && !need_second
		&& !term;
	wire idle_take = state_reg == CLBC_IDLE && req_valid;
	wire done_take = cyc_done && !p_full_reg && req_valid;
	assign req_ready = clk_en && !srst && (idle_take || take_pipe || done_take);
	// Hidden upper half lands on D0-D15 when half width was applied
	wire [15:0] up_src = (half_seen && (second_reg || cur.upper_only))
		? data_lines_in[15:0] : data_lines_in[31:16];
	wire [15:0] lo_src = second_reg ? rdata_reg[15:0] : data_lines_in[15:0];

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			CLBC_IDLE: if (req_valid) state_next = CLBC_FIRST;
			CLBC_FIRST: state_next = CLBC_LATER;
			CLBC_LATER: begin
				if (need_second) state_next = CLBC_FIRST;
				else if (take_pipe) state_next = CLBC_PIPE;
				else if (cyc_done) state_next = req_valid ? CLBC_FIRST : CLBC_IDLE;
			end
			CLBC_PIPE: if (cyc_done) state_next = CLBC_LATER;
			default: state_next = CLBC_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= CLBC_IDLE;
			second_reg <= 1'b0;
			p_full_reg <= 1'b0;
			rsp_reg <= 1'b0;
			lock_out_reg <= 1'b0;
			pipe_fresh_reg <= 1'b0;
			pipe_start_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			// Strobe for a pipelined address stands for one state only
			pipe_fresh_reg <= take_pipe;
			pipe_start_reg <= state_reg == CLBC_PIPE && cyc_done;
			rsp_reg <= cyc_done && is_read;
			if (need_second) second_reg <= 1'b1;
			else if (cyc_done) second_reg <= 1'b0;
			if (take_pipe) p_full_reg <= 1'b1;
			else if (cyc_done) p_full_reg <= 1'b0;
			// Lock rises at the end of the FIRST state of a locked cycle, never for one entered by pipelining; drops on its final termination
			if (state_reg == CLBC_FIRST && lock_reg) lock_out_reg <= 1'b1;
			else if (cyc_done && !(p_full_reg && p_lock_reg)
				&& !(state_next == CLBC_FIRST && req_lock)) lock_out_reg <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			waddr_reg <= RST_WADDR;
			lanes_reg <= ~RST_LANES_N;
			type_reg <= RST_TYPE;
			wdata_reg <= '0;
			lock_reg <= 1'b0;
			rdata_reg <= '0;
			p_waddr_reg <= '0;
			p_lanes_reg <= '0;
			p_type_reg <= RST_TYPE;
			p_wdata_reg <= '0;
			p_lock_reg <= 1'b0;
		end else if (clk_en) begin
			if (term && is_read) rdata_reg <= {up_src, lo_src};
			if (need_second) lanes_reg <= second_lanes;
			else if (idle_take || done_take) begin
				waddr_reg <= in_waddr;
				lanes_reg <= in_lanes;
				type_reg <= in_type;
				wdata_reg <= req_wdata;
				lock_reg <= req_lock;
			end else if (cyc_done && p_full_reg) begin
				waddr_reg <= p_waddr_reg;
				lanes_reg <= p_lanes_reg;
				type_reg <= p_type_reg;
				wdata_reg <= p_wdata_reg;
				lock_reg <= p_lock_reg;
			end
			if (take_pipe) begin
				p_waddr_reg <= in_waddr;
				p_lanes_reg <= in_lanes;
				p_type_reg <= in_type;
				p_wdata_reg <= req_wdata;
				p_lock_reg <= req_lock;
			end
		end
	end

	// ------------------------------------------------------------
	// Pin outputs
	// ------------------------------------------------------------
	wire show_pipe = state_reg == CLBC_PIPE;
	wire [2:0] pin_type = show_pipe ? p_type_reg : type_reg;
	wire strobe = state_reg == CLBC_FIRST || (show_pipe && pipe_fresh_reg);
	// During a pipelined state the address, lane and type pins already show the next cycle; data lines keep the current one
	assign word_address_bits = show_pipe ? p_waddr_reg : waddr_reg;
	assign byte_lane_select_n = ~(show_pipe ? p_lanes_reg : lanes_reg);
	assign mem_io = pin_type[2];
	assign data_code = pin_type[1];
	// Idle bus keeps the last cycle type, so reset shows 010 with the strobe high
	assign write_read = pin_type[0];
	assign lock_n = !lock_out_reg;
	assign address_strobe_n = !strobe;
	assign data_lines_out = cur.drv_data;
	assign data_lines_oe_n = !(drives_data && state_reg != CLBC_IDLE);
	assign rsp_valid = rsp_reg;
	assign rsp_rdata = rdata_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic unused_ok;
	assign unused_ok = strobe ^ is_write;
	a_no_type_one: assert property (@(posedge clock) disable iff (srst)
		!address_strobe_n |-> {mem_io, data_code, write_read} != 3'h1)
		else $error("Type 001 with strobe");
	a_strobe_first: assert property (@(posedge clock) disable iff (srst)
		!address_strobe_n |-> state_reg == CLBC_FIRST || show_pipe)
		else $error("Strobe outside first or pipelined state");
	a_min_two: assert property (@(posedge clock) disable iff (srst || !clk_en)
		state_reg == CLBC_FIRST ##1 clk_en |-> !rsp_valid)
		else $error("Cycle shorter than two states");
	a_no_early_end: assert property (@(posedge clock) disable iff (srst)
		state_reg == CLBC_FIRST |-> !term)
		else $error("Termination taken in first state");
	a_halt_addr: assert property (@(posedge clock) disable iff (srst)
		!address_strobe_n && type_reg == CLBC_HALT_SHUT |->
		word_address_bits == HALT_WADDR && (byte_lane_select_n == ~HALT_LANES
		|| byte_lane_select_n == ~SHUT_LANES))
		else $error("Bad halt or shutdown address");
	a_dup_lower: assert property (@(posedge clock) disable iff (srst)
		!data_lines_oe_n && lanes_reg[3:2] != 2'h0 && lanes_reg[1:0] == 2'h0 |->
		data_lines_out[15:0] == data_lines_out[31:16])
		else $error("Upper write data not duplicated");
	a_write_drive: assert property (@(posedge clock) disable iff (srst)
		state_reg != CLBC_IDLE && type_reg[0] |-> !data_lines_oe_n)
		else $error("Write not driving data lines");
	a_second_cycle: assert property (@(posedge clock) disable iff (srst || !clk_en)
		need_second |=> state_reg == CLBC_FIRST && lanes_reg[1:0] == 2'h0)
		else $error("Missing extra half-width cycle");
	a_lock_drop: assert property (@(posedge clock) disable iff (srst || !clk_en)
		cyc_done && !p_full_reg && state_next == CLBC_IDLE |=> lock_n)
		else $error("Lock held after final cycle");
	a_lane_count: assert property (@(posedge clock) disable iff (srst)
		!address_strobe_n |-> byte_lane_select_n != 4'hF)
		else $error("No lane selected with strobe");
	a_read_full: assert property (@(posedge clock) disable iff (srst || !clk_en)
		term && is_read && !half_seen && !second_reg |=>
		rsp_rdata == $past(data_lines_in))
		else $error("Read data not latched at termination");
	a_read_upper: assert property (@(posedge clock) disable iff (srst || !clk_en)
		term && is_read && half_seen && cur.upper_only |=>
		rsp_rdata[31:16] == $past(data_lines_in[15:0]))
		else $error("Upper bytes not taken from low lines");
	a_lock_rise: assert property (@(posedge clock) disable iff (srst || !clk_en)
		state_reg == CLBC_FIRST && lock_reg |=> !lock_n)
		else $error("Lock not driven for locked cycle");
	a_pipe_next: assert property (@(posedge clock) disable iff (srst || !clk_en)
		take_pipe |=> !address_strobe_n && word_address_bits == $past(in_waddr))
		else $error("Pipelined address not shown");
	c_pipe: cover property (@(posedge clock) take_pipe);
	c_lock: cover property (@(posedge clock) !lock_n && !address_strobe_n);
	c_split: cover property (@(posedge clock) need_second);
	c_read: cover property (@(posedge clock) rsp_valid);
	c_halt: cover property (@(posedge clock) !address_strobe_n && type_reg == CLBC_HALT_SHUT);
endmodule

// ---- bench/clbc_bus_partner.sv ----
// Partner model: memory and bus control logic answering local bus cycles
module clbc_bus_partner (
	input wire logic clock,
	input wire logic srst,
	input wire logic [3:0] wait_states,
	input wire logic half_width_bus_n_req,
	input wire logic [31:0] mem_word,
	input wire logic [3:0] byte_lane_select_n,
	input wire logic address_strobe_n,
	input wire logic [31:0] data_lines_out,
	input wire logic data_lines_oe_n,
	output logic ready_n,
	output logic half_width_bus_n,
	output logic [31:0] data_lines_in,
	output logic [31:0] seen_data,
	output logic seen_oe_n,
	output int strobe_count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy;
	logic tail;
	logic [3:0] cnt;
	logic [3:0] hold;
	logic [31:0] val;
	// A half-width cycle with no low lane gets its upper half on the low lines
	assign val = (half_width_bus_n_req && byte_lane_select_n[1:0] == 2'b11) ? {2{mem_word[31:16]}} : mem_word;
	// Released lines show the inverse so a stale value cannot pass
	assign data_lines_in = (hold != 4'h0) ? val : ~val;
	assign half_width_bus_n = ~half_width_bus_n_req;
	always @(posedge clock) begin
		ready_n <= !tail;
		tail <= 1'b0;
		if (srst) begin
			ready_n <= 1'b1;
			busy <= 1'b0;
			hold <= 4'h0;
			strobe_count <= 0;
		end else if (!address_strobe_n && !busy) begin
			busy <= 1'b1;
			cnt <= wait_states;
			hold <= 4'hF;
			strobe_count <= strobe_count + 1;
		end else if (busy && cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end else if (busy) begin
			// Two low states pass the pin filter yet end before the next cycle samples
			ready_n <= 1'b0;
			tail <= 1'b1;
			busy <= 1'b0;
			seen_data <= data_lines_out;
			seen_oe_n <= data_lines_oe_n;
		end else if (hold != 4'h0) begin
			hold <= hold - 4'h1;
		end
	end
endmodule

// ---- bench/tb_clbc_bus_cycle.sv ----
// Testbench: self-checking bench for the local bus cycle sequencer
module tb_clbc_bus_cycle import clbc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] MEM = 32'h5A3C_96E1;
	localparam logic [31:0] WDATA = 32'hA1B2_C3D4;
	logic clock, srst, req_valid, req_ready, req_lock, req_halt, rsp_valid;
	logic [29:0] req_waddr, word_address_bits, st_addr;
	logic [3:0] req_lanes, byte_lane_select_n, st_lanes, ws;
	logic [2:0] req_type, st_type;
	logic [31:0] req_wdata, rsp_rdata, data_lines_in, data_lines_out, seen_data;
	logic mem_io, data_code, write_read, lock_n, address_strobe_n, ready_n;
	logic half_width_bus_n, data_lines_oe_n, half_width_bus_n_req, seen_oe_n;
	int strobe_count, fail_count, cmp_count;
	clbc_bus_cycle u_clbc_bus_cycle (.clock(clock), .srst(srst), .clk_en(1'b1),
		.req_valid(req_valid), .req_ready(req_ready), .req_waddr(req_waddr),
		.req_lanes(req_lanes), .req_type(req_type), .req_lock(req_lock),
		.req_halt(req_halt), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .word_address_bits(word_address_bits),
		.byte_lane_select_n(byte_lane_select_n), .mem_io(mem_io), .data_code(data_code),
		.write_read(write_read), .lock_n(lock_n), .address_strobe_n(address_strobe_n),
		.ready_n(ready_n), .next_address_request_n(1'b1),
		.half_width_bus_n(half_width_bus_n), .data_lines_in(data_lines_in),
		.data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
	clbc_bus_partner u_clbc_bus_partner (.clock(clock), .srst(srst), .wait_states(ws),
		.half_width_bus_n_req(half_width_bus_n_req), .mem_word(MEM), .byte_lane_select_n(byte_lane_select_n),
		.address_strobe_n(address_strobe_n), .data_lines_out(data_lines_out),
		.data_lines_oe_n(data_lines_oe_n), .ready_n(ready_n),
		.half_width_bus_n(half_width_bus_n), .data_lines_in(data_lines_in),
		.seen_data(seen_data), .seen_oe_n(seen_oe_n), .strobe_count(strobe_count));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Cycle definition is captured in the strobe cycle itself
	always @(posedge clock) begin
		if (address_strobe_n === 1'b0) begin
			st_type <= {mem_io, data_code, write_read};
			st_addr <= word_address_bits;
			st_lanes <= byte_lane_select_n;
			if ({mem_io, data_code, write_read} === IDLE_TYPE) chk("strobe type", 1, 0);
		end
	end
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic issue(input logic [29:0] a, input logic [3:0] l, input logic [2:0] t,
		input logic lk, input logic h);
		int n;
		@(posedge clock);
		{req_valid, req_waddr, req_lanes, req_type} <= {1'b1, a, l, t};
		{req_lock, req_halt, req_wdata} <= {lk, h, WDATA};
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (req_ready !== 1'b1 && n < 200);
		@(posedge clock);
		req_valid <= 1'b0;
		if (n >= 200) chk("req_ready", 1, 0);
	endtask
	// Waits for the partner's termination, or for read data when rd is set
	task automatic wait_end(input logic rd);
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while ((rd ? rsp_valid : ~ready_n) !== 1'b1 && n < 300);
		if (n >= 300) chk("cycle end", 1, 0);
	endtask
	task automatic t_write(input logic [3:0] l, input logic [2:0] t, input logic [29:0] a);
		logic [31:0] m, e;
		logic up;
		up = l[1:0] == 2'h0;
		// Only upper-only writes are copied down; unselected lanes stay undefined
		m = {{8{l[3]}}, {8{l[2]}}, {8{l[1] || (up && l[3])}}, {8{l[0] || (up && l[2])}}};
		e = up ? {2{WDATA[31:16]}} : WDATA;
		issue(a, l, t, 1'b0, 1'b0);
		wait_end(1'b0);
		chk("write data", e & m, seen_data & m);
		chk("write oe_n", 0, seen_oe_n);
		chk("write lanes_n", {28'h0, ~l}, st_lanes);
		chk("write type", t, st_type);
		chk("write addr", a, st_addr);
		$display("write lanes %h type %h done", l, t);
	endtask
	task automatic t_read(input logic [3:0] l, input logic [2:0] t, input logic bs, input int ns);
		logic [31:0] m;
		int s0;
		m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
		s0 = strobe_count;
		issue(30'h0000_0100, l, t, t == CLBC_INTA, 1'b0);
		half_width_bus_n_req <= bs;
		ws <= bs ? 4'h3 : 4'h0;
		wait_end(1'b0);
		if (t == CLBC_INTA) chk("lock_n", 0, lock_n);
		wait_end(1'b1);
		chk("read data", MEM & m, rsp_rdata & m);
		chk("read strobes", ns, strobe_count - s0);
		chk("read type", t, st_type);
		repeat (2) @(negedge clock);
		chk("lock_n", 1, lock_n);
		@(posedge clock);
		half_width_bus_n_req <= 1'b0;
		$display("read lanes %h type %h half %b done", l, t, bs);
	endtask
	task automatic t_halt(input logic [3:0] l);
		issue(HALT_WADDR, l, CLBC_HALT_SHUT, 1'b0, 1'b1);
		wait_end(1'b0);
		chk("halt addr", HALT_WADDR, st_addr);
		chk("halt lanes_n", {28'h0, ~l}, st_lanes);
		chk("halt type", CLBC_HALT_SHUT, st_type);
		chk("halt oe_n", 0, seen_oe_n);
		$display("halt lanes %h done", l);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		finish_test();
	end
	initial begin
		{srst, req_valid, req_lock, req_halt, half_width_bus_n_req} = 5'b1_0000;
		{req_waddr, req_lanes, req_type, req_wdata, ws} = '0;
		fail_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge clock);
		@(negedge clock);
		chk("reset strobe", 1, address_strobe_n);
		chk("reset addr", RST_WADDR, word_address_bits);
		chk("reset type", RST_TYPE, {mem_io, data_code, write_read});
		chk("reset oe_n", 1, data_lines_oe_n);
		chk("reset lanes_n", RST_LANES_N, byte_lane_select_n);
		chk("reset lock_n", 1, lock_n);
		@(posedge clock);
		srst <= 1'b0;
		t_write(4'h4, CLBC_MEM_WR, 30'h0000_0040);
		t_write(4'h8, CLBC_MEM_WR, 30'h0000_0041);
		t_write(4'hC, CLBC_MEM_WR, 30'h3FFF_FFFF);
		t_write(4'hF, CLBC_IO_WR, IO_ADDR_MAX[31:2]);
		// Coprocessor traffic never runs half-width
		t_write(4'hF, CLBC_IO_WR, COP_ADDR_LO[31:2]);
		t_read(4'hF, CLBC_MEM_RD, 1'b0, 1);
		t_read(4'hF, CLBC_MEM_RD, 1'b1, 2);
		t_read(4'h6, CLBC_IO_RD, 1'b1, 2);
		t_read(4'hC, CLBC_CODE_RD, 1'b1, 1);
		t_read(4'h3, CLBC_INTA, 1'b1, 1);
		t_halt(HALT_LANES);
		t_halt(SHUT_LANES);
		finish_test();
	end
endmodule
